// File: src/bimgl_regs.vh
`ifndef BIMGL_REGS_VH
`define BIMGL_REGS_VH
// ==========================================================
// Register offsets (byte addresses)
`define BIMGL_CTRL_OFF 8'h00
`define BIMGL_STAT_OFF 8'h04
`define BIMGL_ENTRY_OFF 8'h08
`define BIMGL_EXTERNAL_STROBE_CONTROL_OFF 8'h0C
`define BIMGL_BLKCNT_OFF 8'h10
`define BIMGL_WIDTH_OFF 8'h14
// ==========================================================
// Field positions
`define BIMGL_STAT_DONE 0
`define BIMGL_STAT_BUSY 1
`define BIMGL_STAT_SER 2
`define BIMGL_STAT_MAP 3
`define BIMGL_STAT_ERR 4
`define BIMGL_CTRL_START 0
// ==========================================================
// Boot image constants
`define BIMGL_BOOT_BASE 24'h001000
`define BIMGL_W8 8'h08
`define BIMGL_W16 8'h10
`define BIMGL_W32 8'h20
`define BIMGL_VEC_BASE 24'h809FC1
`define BIMGL_VEC_COUNT 8'h3F
`define BIMGL_STACK_ADDR 24'h809801
`define BIMGL_MAP_DELAY 2'h3
`define BIMGL_SER_BITS 6'h20
`endif

// File: src/bimgl_loader.v
// Function
// [R1] Area-1 select fetches header from 0x1000
// [R2] First word sets width 8/16/32
// [R3] Bytes combine LSB at lowest address
// [R4] Half-words combine lower half first
// [R5] 32-bit: width, strobe, size, destination
// [R6] Copy size words to consecutive destinations
// [R7] Accept multiple blocks, each own destination
// [R8] Branch to first block destination
// [R9] Supplier gives at least one block
// [R10] Serial select line low picks serial
// [R11] Serial fixed 32-bit burst on sync
// [R12] Host generates serial clock and sync
// [R13] Serial image skips width and strobe
// [R14] Serial words arrive MSB first
// [R15] Boot vectors in top 63 RAM words
// [R16] Fixed vector slot per interrupt source
// [R17] Image must not overwrite vector slots
// [R18] One-word stack at 809801h
// [R19] Interrupt flags left untouched
// [R20] Mode pin held high during boot
// [R21] Low area external three cycles after
// [R22] Zero size ends image, then branch
// [R23] Destinations not below 1000h
// [R24] Ascending reads, no gaps
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "bimgl_regs.vh"
module bimgl_loader #(
    parameter AW = 24
) (
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Select pins, active low except boot_mode_select_pin (boot with it high)
    input wire boot_area1_select_line_n,
    input wire serial_boot_select_line_n,
    input wire boot_mode_select_pin,
    // External boot memory read port
    output reg [AW-1:0] mem_addr,
    output reg mem_rd,
    input wire [31:0] mem_rdata,
    input wire mem_ack,
    // Serial receive pins
    input wire serial_clk,
    input wire serial_dr,
    input wire receive_frame_sync,
    // Destination write port
    output reg [AW-1:0] dst_addr,
    output reg [31:0] dst_data,
    output reg dst_we,
    // Core hand-off
    output reg branch_valid,
    output reg [AW-1:0] branch_addr,
    output reg [AW-1:0] stack_ptr,
    output reg [AW-1:0] vector_base,
    output reg low_area_external
);
    // ==========================================================
    // States
    localparam S_IDLE = 3'h0;
    localparam S_FETCH = 3'h1;
    localparam S_WAIT = 3'h2;
    localparam S_SER = 3'h3;
    localparam S_WORD = 3'h4;
    localparam S_DONE = 3'h5;
    localparam F_WIDTH = 2'h0;
    localparam F_EXTERNAL_STROBE_CONTROL = 2'h1;
    localparam F_SIZE = 2'h2;
    localparam F_DEST = 2'h3;

    // Units per word for a width code
    function [2:0] units_of;
        input [7:0] w;
        begin
            case (w)
                `BIMGL_W8: units_of = 3'h4;
                `BIMGL_W16: units_of = 3'h2;
                default: units_of = 3'h1;
            endcase
        end
    endfunction

    // ==========================================================
    // Pin synchronisers
    reg [1:0] a1_s_r, ser_s_r, mode_s_r, sck_s_r, sdr_s_r, fs_s_r;
    reg sck_d_r, fs_d_r;
    always @(posedge aclk) begin
        if (!aresetn) begin
            a1_s_r <= 2'h3;
            ser_s_r <= 2'h3;
            // Match mode_d_r so reset gives no false mode change
            mode_s_r <= 2'h3;
            sck_s_r <= 2'h0;
            sdr_s_r <= 2'h0;
            fs_s_r <= 2'h0;
            sck_d_r <= 1'b0;
            fs_d_r <= 1'b0;
        end else begin
            a1_s_r <= {a1_s_r[0], boot_area1_select_line_n};
            ser_s_r <= {ser_s_r[0], serial_boot_select_line_n};
            mode_s_r <= {mode_s_r[0], boot_mode_select_pin};
            sck_s_r <= {sck_s_r[0], serial_clk};
            sdr_s_r <= {sdr_s_r[0], serial_dr};
            fs_s_r <= {fs_s_r[0], receive_frame_sync};
            sck_d_r <= sck_s_r[1];
            fs_d_r <= fs_s_r[1];
        end
    end
    wire sck_fall = sck_d_r & ~sck_s_r[1];
    wire fs_rise = fs_s_r[1] & ~fs_d_r;

    // ==========================================================
    // Registers and loader state
    reg [2:0] st_r;
    reg [1:0] fld_r;
    reg [7:0] width_r;
    reg [31:0] external_strobe_control_r;
    reg [31:0] size_r;
    reg [AW-1:0] dest_r;
    reg [AW-1:0] first_r;
    reg first_seen_r;
    reg dest_ok_r;
    reg [31:0] asm_r;
    reg [2:0] unit_r;
    reg serial_r;
    reg done_r;
    reg err_r;
    reg [15:0] blkcnt_r;
    reg start_r;
    reg [5:0] bitcnt_r;
    reg ser_act_r;
    reg mode_d_r;
    reg [1:0] map_cnt_r;
    reg [31:0] word_r;

    // Word assembly
    wire [2:0] units = (st_r == S_WAIT && fld_r == F_WIDTH && unit_r == 3'h0) ?
        units_of(mem_rdata[7:0]) : units_of(width_r);
    reg [31:0] asm_nxt;
    always @* begin
        asm_nxt = asm_r;
        case (units)
            // [R3] Byte little-endian packing
            3'h4: asm_nxt[unit_r[1:0]*8 +: 8] = mem_rdata[7:0];
            // [R4] Lower half first
            3'h2: asm_nxt[unit_r[0]*16 +: 16] = mem_rdata[15:0];
            default: asm_nxt = mem_rdata;
        endcase
    end

    wire aw_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
    // ==========================================================
    // Loader sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= S_IDLE;
            fld_r <= F_WIDTH;
            width_r <= `BIMGL_W32;
            external_strobe_control_r <= 32'h0;
            size_r <= 32'h0;
            dest_r <= {AW{1'b0}};
            first_r <= {AW{1'b0}};
            first_seen_r <= 1'b0;
            dest_ok_r <= 1'b0;
            asm_r <= 32'h0;
            unit_r <= 3'h0;
            serial_r <= 1'b0;
            done_r <= 1'b0;
            err_r <= 1'b0;
            blkcnt_r <= 16'h0;
            mem_addr <= {AW{1'b0}};
            mem_rd <= 1'b0;
            dst_addr <= {AW{1'b0}};
            dst_data <= 32'h0;
            dst_we <= 1'b0;
            branch_valid <= 1'b0;
            branch_addr <= {AW{1'b0}};
            bitcnt_r <= 6'h0;
            ser_act_r <= 1'b0;
            word_r <= 32'h0;
        end else begin
            dst_we <= 1'b0;
            case (st_r)
                S_IDLE: begin
                    // [R20] Boot only with mode pin high
                    if (mode_s_r[1] && !done_r) begin
                        // [R10] Serial select wins
                        if (!ser_s_r[1]) begin
                            serial_r <= 1'b1;
                            // [R13] Start at block size
                            fld_r <= F_SIZE;
                            bitcnt_r <= 6'h0;
                            ser_act_r <= 1'b0;
                            st_r <= S_SER;
                        // [R1] Area-1 memory boot
                        end else if (start_r || !a1_s_r[1]) begin
                            serial_r <= 1'b0;
                            fld_r <= F_WIDTH;
                            unit_r <= 3'h0;
                            mem_addr <= `BIMGL_BOOT_BASE;
                            st_r <= S_FETCH;
                        end
                    end
                end
                S_FETCH: begin
                    mem_rd <= 1'b1;
                    st_r <= S_WAIT;
                end
                S_WAIT: begin
                    if (mem_ack) begin
                        mem_rd <= 1'b0;
                        asm_r <= asm_nxt;
                        // Later units of the width word need the new width
                        if (fld_r == F_WIDTH && unit_r == 3'h0) begin
                            width_r <= mem_rdata[7:0];
                        end
                        // [R24] Next ascending address
                        mem_addr <= mem_addr + 1'b1;
                        if (unit_r + 3'h1 >= units) begin
                            unit_r <= 3'h0;
                            word_r <= asm_nxt;
                            st_r <= S_WORD;
                        end else begin
                            unit_r <= unit_r + 3'h1;
                            st_r <= S_FETCH;
                        end
                    end
                end
                S_SER: begin
                    // [R11] Fixed 32-bit burst on sync
                    if (fs_rise && !ser_act_r) begin
                        ser_act_r <= 1'b1;
                        bitcnt_r <= 6'h0;
                    end else if (ser_act_r && sck_fall) begin
                        // [R14] Shift in MSB first
                        word_r <= {word_r[30:0], sdr_s_r[1]};
                        if (bitcnt_r == `BIMGL_SER_BITS - 6'h1) begin
                            ser_act_r <= 1'b0;
                            st_r <= S_WORD;
                        end
                        bitcnt_r <= bitcnt_r + 6'h1;
                    end
                end
                S_WORD: begin
                    st_r <= serial_r ? S_SER : S_FETCH;
                    case (fld_r)
                        F_WIDTH: begin
                            // [R2] Width code
                            width_r <= word_r[7:0];
                            err_r <= (units_of(word_r[7:0]) == 3'h1) &&
                                (word_r[7:0] != `BIMGL_W32);
                            fld_r <= F_EXTERNAL_STROBE_CONTROL;
                        end
                        // [R5] Strobe word follows width
                        F_EXTERNAL_STROBE_CONTROL: begin
                            external_strobe_control_r <= word_r;
                            fld_r <= F_SIZE;
                        end
                        F_SIZE: begin
                            size_r <= word_r;
                            dest_ok_r <= 1'b0;
                            fld_r <= F_DEST;
                            // [R22] Zero size ends image
                            if (word_r == 32'h0) begin
                                st_r <= S_DONE;
                            end
                        end
                        default: begin
                            if (!dest_ok_r) begin
                                dest_r <= word_r[AW-1:0];
                                dest_ok_r <= 1'b1;
                                if (!first_seen_r) begin
                                    first_r <= word_r[AW-1:0];
                                    first_seen_r <= 1'b1;
                                end
                            end else if (size_r != 32'h0) begin
                                // [R6] Copy one word
                                dst_addr <= dest_r;
                                dst_data <= word_r;
                                dst_we <= 1'b1;
                                dest_r <= dest_r + 1'b1;
                                size_r <= size_r - 32'h1;
                                if (size_r == 32'h1) begin
                                    // [R7] Next block header
                                    fld_r <= F_SIZE;
                                    blkcnt_r <= blkcnt_r + 16'h1;
                                end
                            end
                        end
                    endcase
                end
                S_DONE: begin
                    // [R8] Branch to first block
                    branch_addr <= first_r;
                    branch_valid <= 1'b1;
                    done_r <= 1'b1;
                    st_r <= S_IDLE;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Fixed boot-time placement
    always @(posedge aclk) begin
        if (!aresetn) begin
            stack_ptr <= {AW{1'b0}};
            vector_base <= {AW{1'b0}};
        end else begin
            // [R18] One-word stack
            stack_ptr <= `BIMGL_STACK_ADDR;
            // [R15] [R16] Vectors at top 63 words
            vector_base <= `BIMGL_VEC_BASE;
        end
    end

    // ==========================================================
    // Low area remap after mode change
    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_d_r <= 1'b1;
            map_cnt_r <= 2'h0;
            low_area_external <= 1'b0;
        end else begin
            mode_d_r <= mode_s_r[1];
            // [R21] Remap three cycles after change
            if (mode_d_r != mode_s_r[1]) begin
                map_cnt_r <= `BIMGL_MAP_DELAY - 2'h1;
            end else if (map_cnt_r != 2'h0) begin
                map_cnt_r <= map_cnt_r - 2'h1;
                if (map_cnt_r == 2'h1) begin
                    low_area_external <= ~mode_s_r[1];
                end
            end
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    // [R19] Interrupt flags untouched
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0;
            start_r <= 1'b0;
        end else begin
            s_axi_awready <= aw_go;
            s_axi_wready <= aw_go;
            if (aw_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (s_axi_awaddr == `BIMGL_CTRL_OFF) ? 2'h0 : 2'h2;
                if (s_axi_awaddr == `BIMGL_CTRL_OFF && s_axi_wstrb[0]) begin
                    start_r <= s_axi_wdata[`BIMGL_CTRL_START];
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    `BIMGL_CTRL_OFF: s_axi_rdata <= {31'h0, start_r};
                    `BIMGL_STAT_OFF: s_axi_rdata <= {27'h0, err_r, low_area_external,
                        serial_r, st_r != S_IDLE, done_r};
                    `BIMGL_ENTRY_OFF: s_axi_rdata <= {{(32-AW){1'b0}}, branch_addr};
                    `BIMGL_EXTERNAL_STROBE_CONTROL_OFF: s_axi_rdata <= external_strobe_control_r;
                    `BIMGL_BLKCNT_OFF: s_axi_rdata <= {16'h0, blkcnt_r};
                    `BIMGL_WIDTH_OFF: s_axi_rdata <= {24'h0, width_r};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // bimgl_loader
`default_nettype wire

// File: dv/bimgl_loader_sva.sv
`timescale 1ns/1ns
`default_nettype none
module bimgl_loader_chk #(
    parameter AW = 24
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic boot_mode_select_pin,
    input wire logic [AW-1:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_ack,
    input wire logic dst_we,
    input wire logic branch_valid,
    input wire logic [AW-1:0] branch_addr,
    input wire logic [AW-1:0] stack_ptr,
    input wire logic [AW-1:0] vector_base,
    input wire logic low_area_external
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
// ==========================================
// Helper state
logic seen_r;
logic [AW-1:0] last_r;
always @(posedge aclk) begin
    if (!aresetn)
        seen_r <= 1'b0;
    else if (mem_rd && mem_ack)
        seen_r <= 1'b1;
    if (mem_rd && mem_ack)
        last_r <= mem_addr;
end
// ==========================================
// Properties
property p_stack; $past(aresetn) |-> stack_ptr == 24'h809801; endproperty
a_stack: assert property (p_stack) else $error("stack pointer wrong");
property p_vec; $past(aresetn) |-> vector_base == 24'h809FC1; endproperty
a_vec: assert property (p_vec) else $error("vector base wrong");
property p_first; mem_rd && !seen_r |-> mem_addr == 24'h001000; endproperty
a_first: assert property (p_first) else $error("first fetch address wrong");
property p_next; $rose(mem_rd) && seen_r |-> mem_addr == last_r + 1; endproperty
a_next: assert property (p_next) else $error("fetch address not ascending");
property p_hold; mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr); endproperty
a_hold: assert property (p_hold) else $error("fetch dropped before ack");
property p_we; dst_we |=> !dst_we; endproperty
a_we: assert property (p_we) else $error("write strobe longer than one cycle");
property p_brk; branch_valid |=> branch_valid && $stable(branch_addr); endproperty
a_brk: assert property (p_brk) else $error("branch not held");
property p_quiet; branch_valid |-> !dst_we && !mem_rd; endproperty
a_quiet: assert property (p_quiet) else $error("activity after end of image");
property p_map;
    $fell(boot_mode_select_pin) && !low_area_external
        |=> !low_area_external [*2] ##[1:6] low_area_external;
endproperty
a_map: assert property (p_map) else $error("low area remap timing wrong");
c_branch: cover property ($rose(branch_valid));
c_write: cover property (dst_we);
c_map: cover property ($rose(low_area_external));
endmodule // bimgl_loader_chk
bind bimgl_loader bimgl_loader_chk #(.AW(AW)) u_chk (.aclk(aclk), .aresetn(aresetn),
    .boot_mode_select_pin(boot_mode_select_pin), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_ack(mem_ack), .dst_we(dst_we), .branch_valid(branch_valid),
    .branch_addr(branch_addr), .stack_ptr(stack_ptr), .vector_base(vector_base),
    .low_area_external(low_area_external));
`default_nettype wire

// File: dv/bimgl_boot_mem.sv
`timescale 1ns/1ns
`default_nettype none
module bimgl_boot_mem (
    input wire logic aclk,
    input wire logic [23:0] mem_addr,
    input wire logic mem_rd,
    input wire logic [7:0] width,
    input wire logic [1:0] lag,
    output logic [31:0] mem_rdata,
    output logic mem_ack
);
logic [31:0] img [0:63];
logic [23:0] off;
int cnt = 0;
assign off = mem_addr - 24'h001000;
initial mem_ack = 1'b0;
initial mem_rdata = 32'h0;
// ==========================================
// Read port, bus shows junk when idle
always @(posedge aclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_rd && !mem_ack) begin
        if (cnt < lag) begin
            cnt <= cnt + 1;
        end else begin
            cnt <= 0;
            mem_ack <= 1'b1;
            if (width == 8'h08)
                mem_rdata <= {24'h0, img[off >> 2] >> (8 * off[1:0])} & 32'hFF;
            else if (width == 8'h10)
                mem_rdata <= (img[off >> 1] >> (16 * off[0])) & 32'hFFFF;
            else
                mem_rdata <= img[off];
        end
    end
end
endmodule // bimgl_boot_mem
`default_nettype wire

// File: dv/bimgl_loader_bench.sv
`timescale 1ns/1ns
`default_nettype none
module bimgl_loader_bench;
logic aclk = 0, aresetn = 0;
logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, mem_w = 8'h20;
logic [31:0] s_axi_wdata = 0, s_axi_rdata, mem_rdata;
logic [3:0] s_axi_wstrb = 0;
logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
logic s_axi_rvalid, mem_rd, mem_ack, dst_we, branch_valid, low_area_external;
logic [1:0] s_axi_bresp, s_axi_rresp, lag = 0;
logic boot_area1_select_line_n = 1, serial_boot_select_line_n = 1, boot_mode_select_pin = 1;
logic serial_clk = 0, serial_dr = 0, receive_frame_sync = 0;
logic [23:0] mem_addr, dst_addr, branch_addr, stack_ptr, vector_base;
logic [31:0] dst_data;
logic [55:0] expq[$];
logic [55:0] e;
int bad_count = 0, num_checks = 0, seed = 32'hf014cd2c;
bimgl_loader u_bimgl_loader (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .boot_area1_select_line_n(boot_area1_select_line_n),
    .serial_boot_select_line_n(serial_boot_select_line_n),
    .boot_mode_select_pin(boot_mode_select_pin), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .serial_clk(serial_clk),
    .serial_dr(serial_dr), .receive_frame_sync(receive_frame_sync), .dst_addr(dst_addr),
    .dst_data(dst_data), .dst_we(dst_we), .branch_valid(branch_valid),
    .branch_addr(branch_addr), .stack_ptr(stack_ptr), .vector_base(vector_base),
    .low_area_external(low_area_external));
bimgl_boot_mem u_bimgl_boot_mem (.aclk(aclk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .width(mem_w), .lag(lag), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
initial forever #10 aclk = ~aclk;
// ==========================================
// Checking
task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
        bad_count++;
        $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
endtask
always @(posedge aclk) begin
    if (aresetn === 1'b1 && dst_we === 1'b1) begin
        if (expq.size() == 0) begin
            chk("dst_extra", 0, 1);
        end else begin
            e = expq.pop_front();
            chk("dst_addr", {8'h0, e[55:32]}, {8'h0, dst_addr});
            chk("dst_data", e[31:0], dst_data);
        end
    end
end
task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
initial begin
    #1900000;
    bad_count++;
    end_of_test();
end
// ==========================================
// Bus and pin drivers
task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit got = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int i = 0; i < 50 && !got; i++) begin
        @(posedge aclk);
        if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 0;
        if (s_axi_rvalid === 1'b1) begin
            got = 1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 0;
        end
    end
    @(posedge aclk);
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit got = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int i = 0; i < 50 && !got; i++) begin
        @(posedge aclk);
        if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 0;
        if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 0;
        if (s_axi_bvalid === 1'b1) begin
            got = 1;
            r = s_axi_bresp;
            s_axi_bready <= 0;
        end
    end
    @(posedge aclk);
endtask
// host clocks a word out MSB first
task automatic send(input logic [31:0] v);
    // Offset link edges by 5 ns; every fourth word still lands them on aclk rising edges
    #5 receive_frame_sync = 1;
    #80 receive_frame_sync = 0;
    for (int i = 31; i >= 0; i--) begin
        serial_dr = v[i];
        #40 serial_clk = 1;
        #80 serial_clk = 0;
        #40;
    end
    serial_dr = ~v[0];
    #400;
endtask
task automatic boot(input logic [7:0] wd, input bit ser);
    logic [31:0] w[$];
    logic [31:0] d;
    logic [1:0] r;
    logic [23:0] ds;
    int n;
    aresetn <= 0;
    boot_area1_select_line_n <= 1;
    serial_boot_select_line_n <= 1;
    boot_mode_select_pin <= 1;
    expq.delete();
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    if (!ser) begin
        w.push_back({24'h0, wd});
        w.push_back(32'h1058 ^ {$random(seed)} & 32'hF0);
    end
    // two non-empty blocks below the vectors
    for (int b = 0; b < 2; b++) begin
        n = 1 + ({$random(seed)} % 4);
        ds = b ? 24'h809A00 : 24'h809C00;
        w.push_back(n);
        w.push_back({8'h0, ds});
        for (int i = 0; i < n; i++) begin
            d = $random(seed);
            w.push_back(d);
            expq.push_back({ds + i[23:0], d});
        end
    end
    w.push_back(32'h0);
    foreach (w[i]) u_bimgl_boot_mem.img[i] = w[i];
    mem_w <= wd;
    lag <= $random(seed);
    @(posedge aclk);
    if (ser) begin
        serial_boot_select_line_n <= 0;
        // Loader must be waiting before the first frame sync
        repeat (6) @(posedge aclk);
        foreach (w[i]) send(w[i]);
    end else begin
        boot_area1_select_line_n <= 0;
    end
    for (n = 0; n < 20000 && branch_valid !== 1'b1; n++) @(posedge aclk);
    chk("branch_addr", 32'h809C00, {8'h0, branch_addr});
    chk("pending", 0, expq.size());
    rd(8'h04, d, r);
    chk("status", {27'h0, 2'b00, ser, 2'b01}, {27'h0, d[4:0]});
    rd(8'h08, d, r);
    chk("entry", 32'h809C00, d);
    if (!ser) begin
        rd(8'h14, d, r);
        chk("width", w[0], d);
        rd(8'h0C, d, r);
        chk("strobe", w[1], d);
    end
    $display("test boot width %h serial %0d done", wd, ser);
endtask
// ==========================================
// Main sequence
initial begin
    logic [31:0] d;
    logic [1:0] r;
    boot(8'h08, 0);
    boot(8'h10, 0);
    boot(8'h20, 0);
    rd(8'h40, d, r);
    chk("unmapped_resp", 2'b10, r);
    chk("unmapped_data", 0, d);
    wr(8'h40, 32'h1, r);
    chk("unmapped_wr", 2'b10, r);
    wr(8'h00, 32'h0, r);
    chk("ctrl_wr", 2'b00, r);
    boot_mode_select_pin <= 0;
    @(posedge aclk);
    @(posedge aclk);
    chk("remap_early", 0, low_area_external);
    repeat (8) @(posedge aclk);
    chk("remap", 1, low_area_external);
    $display("test remap done");
    boot(8'h20, 1);
    end_of_test();
end
endmodule // bimgl_loader_bench
`default_nettype wire
